/* rtl/pdc_consts.vh */
`ifndef PDC_CONSTS_VH
`define PDC_CONSTS_VH

// ------------------------------------------------------------
// Register addresses
// ------------------------------------------------------------
`define PDC_A_HP_L      16'h4023
`define PDC_A_HP_R      16'h4024
`define PDC_A_LINE_L    16'h4025
`define PDC_A_LINE_R    16'h4026
`define PDC_A_MONO      16'h4027
`define PDC_A_POP       16'h4028
`define PDC_A_PWR       16'h4029
`define PDC_A_CONV      16'h402a
`define PDC_A_ATT_L     16'h402b
`define PDC_A_ATT_R     16'h402c
`define PDC_A_PAD_AUD   16'h402d
`define PDC_A_PAD_CTL   16'h402f

// ------------------------------------------------------------
// Reset values and writable-bit masks
// ------------------------------------------------------------
`define PDC_RST_VOL     8'h02
`define PDC_RST_ZERO    8'h00
`define PDC_RST_PAD     8'haa
`define PDC_MSK_ALL     8'hff
`define PDC_MSK_POP     8'h1e
`define PDC_MSK_PWR     8'h03
`define PDC_MSK_CONV    8'he7

// ------------------------------------------------------------
// Field positions and codes
// ------------------------------------------------------------
`define PDC_LVL_HI      7
`define PDC_LVL_LO      2
`define PDC_BIT_MUTE    1
`define PDC_BIT_LOW     0
`define PDC_POP_LP      4
`define PDC_POP_OFF     3
`define PDC_RAMP_HI     2
`define PDC_RAMP_LO     1
`define PDC_MONO_HI     7
`define PDC_MONO_LO     6
`define PDC_POL         5
`define PDC_EMPH        2
`define PDC_DEN_HI      1
`define PDC_DEN_LO      0
`define PDC_PWR_R       1
`define PDC_PWR_L       0
`define PDC_MIX_CMODE   2'b00
`define PDC_LVL_UNITY   6'h39
`define PDC_RAMP_OFF    2'b11
`define PDC_RAMP_42     2'b01
`define PDC_RAMP_85     2'b10

// ------------------------------------------------------------
// Timing: ramp times in microseconds, 64 codes per full ramp
// ------------------------------------------------------------
`define PDC_CLK_NS      4
`define PDC_RAMP0_US    21250
`define PDC_RAMP1_US    42500
`define PDC_RAMP2_US    85000
`define PDC_LVL_CODES   64
`define PDC_DIG_STEP    8'hff

`endif

/* rtl/pdc_slew.v */
`timescale 1ns/100ps
`default_nettype none
module pdc_slew #(
    parameter W = 6
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire [W-1:0] rst_lvl,
    input  wire [W-1:0] target,
    input  wire         step_tick,
    input  wire         bypass,
    output reg  [W-1:0] level_ff
);
    // ------------------------------------------------------------
    // One code per tick toward the target; avoids zipper noise
    // ------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_ff <= {W{1'b0}};
        end else if (bypass) begin
            level_ff <= target;
        end else if (step_tick && level_ff < target) begin
            level_ff <= level_ff + {{(W-1){1'b0}}, 1'b1};
        end else if (step_tick && level_ff > target) begin
            level_ff <= level_ff - {{(W-1){1'b0}}, 1'b1};
        end
    end
    // rst_lvl kept for callers; all levels reset to code 0
    wire unused_rst = |rst_lvl;
endmodule
`default_nettype wire

/* rtl/pdc_regs.v */
`timescale 1ns/100ps
`default_nettype none
`include "pdc_consts.vh"
module pdc_regs #(
    parameter [19:0] RAMP0_STEP_CYC = (`PDC_RAMP0_US * 1000) / (`PDC_CLK_NS * `PDC_LVL_CODES),
    parameter [19:0] RAMP1_STEP_CYC = (`PDC_RAMP1_US * 1000) / (`PDC_CLK_NS * `PDC_LVL_CODES),
    parameter [19:0] RAMP2_STEP_CYC = (`PDC_RAMP2_US * 1000) / (`PDC_CLK_NS * `PDC_LVL_CODES)
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [15:0] reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire [1:0]  single_mixer_boost,
    output reg  [7:0]  reg_rdata_ff,
    output wire [5:0]  left_phones_level,
    output wire [5:0]  right_phones_level,
    output wire [5:0]  left_line_level,
    output wire [5:0]  right_line_level,
    output wire [5:0]  single_out_level,
    output reg         single_out_level_on_ff,
    output reg         left_phones_unsilence_ff,
    output reg         right_phones_unsilence_ff,
    output reg         left_line_unsilence_ff,
    output reg         right_line_unsilence_ff,
    output reg         single_out_unsilence_ff,
    output reg         phones_out_enable_ff,
    output reg         phones_pin_select_ff,
    output reg         left_line_drive_select_ff,
    output reg         right_line_drive_select_ff,
    output reg         single_out_drive_select_ff,
    output reg         pop_guard_low_power_ff,
    output reg         pop_guard_off_ff,
    output reg  [1:0]  analog_level_ramp_ff,
    output reg         right_play_power_ff,
    output reg         left_play_power_ff,
    output reg  [1:0]  converter_single_channel_ff,
    output reg         converter_invert_ff,
    output reg         emphasis_undo_filter_ff,
    output reg  [1:0]  converter_power_ff,
    output wire [7:0]  left_converter_atten,
    output wire [7:0]  right_converter_atten,
    output reg  [7:0]  audio_pad_pulls_ff,
    output reg  [7:0]  ctrl_pad_pulls_ff
);
    localparam NREG = 12;

    // ------------------------------------------------------------
    // Register index decode, shared by write and read paths
    // ------------------------------------------------------------
    function [3:0] reg_index;
        input [15:0] a;
        begin
            if (a == `PDC_A_HP_L) reg_index = 4'd0;
            else if (a == `PDC_A_HP_R) reg_index = 4'd1;
            else if (a == `PDC_A_LINE_L) reg_index = 4'd2;
            else if (a == `PDC_A_LINE_R) reg_index = 4'd3;
            else if (a == `PDC_A_MONO) reg_index = 4'd4;
            else if (a == `PDC_A_POP) reg_index = 4'd5;
            else if (a == `PDC_A_PWR) reg_index = 4'd6;
            else if (a == `PDC_A_CONV) reg_index = 4'd7;
            else if (a == `PDC_A_ATT_L) reg_index = 4'd8;
            else if (a == `PDC_A_ATT_R) reg_index = 4'd9;
            else if (a == `PDC_A_PAD_AUD) reg_index = 4'd10;
            else if (a == `PDC_A_PAD_CTL) reg_index = 4'd11;
            else reg_index = 4'd15;
        end
    endfunction

    // Reset value and writable mask per index
    function [15:0] reg_init_mask;
        input [3:0] i;
        begin
            if (i <= 4'd4) reg_init_mask = {`PDC_RST_VOL, `PDC_MSK_ALL};
            else if (i == 4'd5) reg_init_mask = {`PDC_RST_ZERO, `PDC_MSK_POP};
            else if (i == 4'd6) reg_init_mask = {`PDC_RST_ZERO, `PDC_MSK_PWR};
            else if (i == 4'd7) reg_init_mask = {`PDC_RST_ZERO, `PDC_MSK_CONV};
            else if (i <= 4'd9) reg_init_mask = {`PDC_RST_ZERO, `PDC_MSK_ALL};
            else reg_init_mask = {`PDC_RST_PAD, `PDC_MSK_ALL};
        end
    endfunction

    wire [3:0] idx = reg_index(reg_addr);
    reg  [7:0] regs_ff [0:NREG-1];

    // ------------------------------------------------------------
    // Register storage; reserved bits masked so they stay zero
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NREG; g = g + 1) begin : g_reg
            // Elaboration constants, so the reset branch loads a true constant
            localparam integer GI = g;
            localparam [15:0]  IM = reg_init_mask(GI[3:0]);
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    regs_ff[g] <= IM[15:8];
                end else if (reg_wr && idx == GI[3:0]) begin
                    regs_ff[g] <= reg_wdata & IM[7:0];
                end
            end
        end
    endgenerate

    // Read port; unmapped addresses and reserved bits read zero
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            if (idx < NREG) begin
                reg_rdata_ff <= regs_ff[idx];
            end else begin
                reg_rdata_ff <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // Ramp tick generators
    // ------------------------------------------------------------
    wire [1:0] ramp_sel = regs_ff[5][`PDC_RAMP_HI:`PDC_RAMP_LO];
    reg  [19:0] ramp_cnt_ff;
    reg  [19:0] ramp_len;
    reg         ana_tick_ff;
    reg  [7:0]  dig_cnt_ff;
    reg         dig_tick_ff;

    // Step period per ramp setting
    always @* begin
        if (ramp_sel == `PDC_RAMP_42) ramp_len = RAMP1_STEP_CYC;
        else if (ramp_sel == `PDC_RAMP_85) ramp_len = RAMP2_STEP_CYC;
        else ramp_len = RAMP0_STEP_CYC;
    end

    // Counter restarts on wrap; a ramp change applies at once to the count already running
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ramp_cnt_ff <= 20'h00000;
            ana_tick_ff <= 1'b0;
            dig_cnt_ff  <= 8'h00;
            dig_tick_ff <= 1'b0;
        end else begin
            if (ramp_cnt_ff + 20'h00001 >= ramp_len) begin
                ramp_cnt_ff <= 20'h00000;
                ana_tick_ff <= 1'b1;
            end else begin
                ramp_cnt_ff <= ramp_cnt_ff + 20'h00001;
                ana_tick_ff <= 1'b0;
            end
            dig_cnt_ff  <= dig_cnt_ff + 8'h01;
            dig_tick_ff <= (dig_cnt_ff == `PDC_DIG_STEP);
        end
    end

    wire ana_bypass = (ramp_sel == `PDC_RAMP_OFF);
    wire mono_cmode = (single_mixer_boost == `PDC_MIX_CMODE);

    // Mono level held at unity in common-mode, field ignored
    wire [5:0] mono_target = mono_cmode ? `PDC_LVL_UNITY :
                             regs_ff[4][`PDC_LVL_HI:`PDC_LVL_LO];

    // ------------------------------------------------------------
    // Level slewers: five analog outputs, two converter attenuators
    // ------------------------------------------------------------
    wire [5:0] ana_target [0:4];
    wire [5:0] ana_level  [0:4];
    assign ana_target[0] = regs_ff[0][`PDC_LVL_HI:`PDC_LVL_LO];
    assign ana_target[1] = regs_ff[1][`PDC_LVL_HI:`PDC_LVL_LO];
    assign ana_target[2] = regs_ff[2][`PDC_LVL_HI:`PDC_LVL_LO];
    assign ana_target[3] = regs_ff[3][`PDC_LVL_HI:`PDC_LVL_LO];
    assign ana_target[4] = mono_target;

    generate
        for (g = 0; g < 5; g = g + 1) begin : g_ana
            pdc_slew #(.W(6)) u_slew (
                .clk       (clk),
                .rst_n     (rst_n),
                .rst_lvl   (6'h00),
                .target    (ana_target[g]),
                .step_tick (ana_tick_ff),
                .bypass    (ana_bypass),
                .level_ff  (ana_level[g])
            );
        end
        for (g = 0; g < 2; g = g + 1) begin : g_dig
            wire [7:0] lvl;
            pdc_slew #(.W(8)) u_slew (
                .clk       (clk),
                .rst_n     (rst_n),
                .rst_lvl   (8'h00),
                .target    (regs_ff[8+g]),
                .step_tick (dig_tick_ff),
                .bypass    (1'b0),
                .level_ff  (lvl)
            );
        end
    endgenerate

    assign left_phones_level     = ana_level[0];
    assign right_phones_level    = ana_level[1];
    assign left_line_level       = ana_level[2];
    assign right_line_level      = ana_level[3];
    assign single_out_level      = ana_level[4];
    assign left_converter_atten  = g_dig[0].lvl;
    assign right_converter_atten = g_dig[1].lvl;

    // ------------------------------------------------------------
    // Control outputs, registered from the register fields and the mixer mode input
    // ------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            single_out_level_on_ff      <= 1'b0;
            left_phones_unsilence_ff    <= 1'b1;
            right_phones_unsilence_ff   <= 1'b1;
            left_line_unsilence_ff      <= 1'b1;
            right_line_unsilence_ff     <= 1'b1;
            single_out_unsilence_ff     <= 1'b1;
            phones_out_enable_ff        <= 1'b0;
            phones_pin_select_ff        <= 1'b0;
            left_line_drive_select_ff   <= 1'b0;
            right_line_drive_select_ff  <= 1'b0;
            single_out_drive_select_ff  <= 1'b0;
            pop_guard_low_power_ff      <= 1'b0;
            pop_guard_off_ff            <= 1'b0;
            analog_level_ramp_ff        <= 2'b00;
            right_play_power_ff         <= 1'b0;
            left_play_power_ff          <= 1'b0;
            converter_single_channel_ff <= 2'b00;
            converter_invert_ff         <= 1'b0;
            emphasis_undo_filter_ff     <= 1'b0;
            converter_power_ff          <= 2'b00;
            audio_pad_pulls_ff          <= `PDC_RST_PAD;
            ctrl_pad_pulls_ff           <= `PDC_RST_PAD;
        end else begin
            single_out_level_on_ff      <= ~mono_cmode;
            left_phones_unsilence_ff    <= regs_ff[0][`PDC_BIT_MUTE];
            right_phones_unsilence_ff   <= regs_ff[1][`PDC_BIT_MUTE];
            left_line_unsilence_ff      <= regs_ff[2][`PDC_BIT_MUTE];
            right_line_unsilence_ff     <= regs_ff[3][`PDC_BIT_MUTE];
            single_out_unsilence_ff     <= regs_ff[4][`PDC_BIT_MUTE];
            phones_out_enable_ff        <= regs_ff[0][`PDC_BIT_LOW] |
                                           regs_ff[1][`PDC_BIT_LOW];
            phones_pin_select_ff        <= regs_ff[1][`PDC_BIT_LOW];
            left_line_drive_select_ff   <= regs_ff[2][`PDC_BIT_LOW];
            right_line_drive_select_ff  <= regs_ff[3][`PDC_BIT_LOW];
            single_out_drive_select_ff  <= regs_ff[4][`PDC_BIT_LOW];
            pop_guard_low_power_ff      <= regs_ff[5][`PDC_POP_LP];
            pop_guard_off_ff            <= regs_ff[5][`PDC_POP_OFF];
            analog_level_ramp_ff        <= ramp_sel;
            right_play_power_ff         <= regs_ff[6][`PDC_PWR_R];
            left_play_power_ff          <= regs_ff[6][`PDC_PWR_L];
            converter_single_channel_ff <= regs_ff[7][`PDC_MONO_HI:`PDC_MONO_LO];
            converter_invert_ff         <= regs_ff[7][`PDC_POL];
            emphasis_undo_filter_ff     <= regs_ff[7][`PDC_EMPH];
            converter_power_ff          <= regs_ff[7][`PDC_DEN_HI:`PDC_DEN_LO];
            audio_pad_pulls_ff          <= regs_ff[10];
            ctrl_pad_pulls_ff           <= regs_ff[11];
        end
    end
endmodule
`default_nettype wire

/* testbench/pdc_regs_props.sv */
`timescale 1ns/100ps
`default_nettype none
module pdc_regs_props (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [1:0]  single_mixer_boost,
    input wire logic [7:0]  reg_rdata_ff,
    input wire logic [5:0]  left_phones_level,
    input wire logic        single_out_level_on_ff,
    input wire logic        left_phones_unsilence_ff,
    input wire logic        single_out_unsilence_ff,
    input wire logic        phones_out_enable_ff,
    input wire logic        phones_pin_select_ff,
    input wire logic [1:0]  analog_level_ramp_ff,
    input wire logic        right_play_power_ff,
    input wire logic        left_play_power_ff,
    input wire logic [7:0]  left_converter_atten,
    input wire logic [7:0]  audio_pad_pulls_ff
);
    default clocking dcb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // Write side effects, two edges from strobe to output
    // ------------------------------------------------------------
    chk_phones_or_select: assert property (phones_pin_select_ff |-> phones_out_enable_ff)
        else $error("phones drive off while pin select is set");
    chk_power_follows_write: assert property (reg_wr && reg_addr == 16'h4029 |-> ##2
        {6'h00, right_play_power_ff, left_play_power_ff} == ($past(reg_wdata, 2) & 8'h03))
        else $error("playback power bits differ from written value");
    chk_phones_mute_write: assert property (reg_wr && reg_addr == 16'h4023 |-> ##2
        {6'h00, left_phones_unsilence_ff, 1'b0} == ($past(reg_wdata, 2) & 8'h02))
        else $error("phones silence bit differs from written value");
    chk_single_mute_write: assert property (reg_wr && reg_addr == 16'h4027 |-> ##2
        {6'h00, single_out_unsilence_ff, 1'b0} == ($past(reg_wdata, 2) & 8'h02))
        else $error("single output silence bit differs from written value");
    chk_pad_pull_write: assert property (reg_wr && reg_addr == 16'h402d |-> ##2
        audio_pad_pulls_ff == $past(reg_wdata, 2))
        else $error("audio pad pulls differ from written value");
    // ------------------------------------------------------------
    // Read port, mixer gating and slewing
    // ------------------------------------------------------------
    chk_unmapped_zero: assert property (reg_rd && reg_addr == 16'h402e |=> reg_rdata_ff == 8'h00)
        else $error("unmapped read returned nonzero");
    chk_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata_ff))
        else $error("read data moved without a read");
    chk_level_gate_mode: assert property ($stable(single_mixer_boost) [*3] |->
        single_out_level_on_ff == (single_mixer_boost != 2'b00))
        else $error("single level enable wrong for mixer mode");
    // Only a bypassed ramp may move a level by more than one code
    chk_level_one_step: assert property (analog_level_ramp_ff != 2'b11 &&
        $past(analog_level_ramp_ff) != 2'b11 |-> left_phones_level == $past(left_phones_level)
        || left_phones_level == $past(left_phones_level) + 6'd1
        || left_phones_level == $past(left_phones_level) - 6'd1)
        else $error("phones level jumped while ramping");
    chk_atten_spacing: assert property (left_converter_atten != $past(left_converter_atten)
        |=> $stable(left_converter_atten))
        else $error("attenuation stepped on consecutive cycles");
    cov_unmapped: cover property (reg_wr && reg_addr == 16'h402e);
    cov_common_mode: cover property (single_mixer_boost == 2'b00 [*3]);
    cov_level_move: cover property (left_phones_level != $past(left_phones_level));
endmodule
bind pdc_regs pdc_regs_props u_props (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .single_mixer_boost(single_mixer_boost), .reg_rdata_ff(reg_rdata_ff),
    .left_phones_level(left_phones_level), .single_out_level_on_ff(single_out_level_on_ff),
    .left_phones_unsilence_ff(left_phones_unsilence_ff),
    .single_out_unsilence_ff(single_out_unsilence_ff),
    .phones_out_enable_ff(phones_out_enable_ff), .phones_pin_select_ff(phones_pin_select_ff),
    .analog_level_ramp_ff(analog_level_ramp_ff), .right_play_power_ff(right_play_power_ff),
    .left_play_power_ff(left_play_power_ff), .left_converter_atten(left_converter_atten),
    .audio_pad_pulls_ff(audio_pad_pulls_ff));
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "pdc_consts.vh"
module tb_top;
    // ------------------------------------------------------------
    // Signals and tables
    // ------------------------------------------------------------
    logic        clk, rst_n, reg_wr, reg_rd;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata;
    logic [1:0]  mix;
    wire  [7:0]  rdata, latt, ratt, apad, cpad;
    wire  [5:0]  lpl, rpl, lll, rll, sol;
    wire  [1:0]  ramp, schan, cpwr;
    wire         lvl_on, lpu, rpu, llu, rlu, sou, phen, psel, lld, rld, sod;
    wire         plp, poff, rpw, lpw, inv, emph;
    integer      n_mismatch, checks, k;
    integer      cyc = 0;
    logic [15:0] adr [12] = '{`PDC_A_HP_L, `PDC_A_HP_R, `PDC_A_LINE_L, `PDC_A_LINE_R,
        `PDC_A_MONO, `PDC_A_POP, `PDC_A_PWR, `PDC_A_CONV, `PDC_A_ATT_L, `PDC_A_ATT_R,
        `PDC_A_PAD_AUD, `PDC_A_PAD_CTL};
    logic [7:0]  rv [12] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'haa, 8'haa};
    logic [7:0]  mk [12] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h1e, 8'h03, 8'he7, 8'hff,
        8'hff, 8'hff, 8'hff};
    // Flags packed for one compare, unsilence bits on top
    wire  [16:0] flags = {lpu, rpu, llu, rlu, sou, phen, psel, lld, rld, sod, plp, poff,
        rpw, lpw, inv, emph, lvl_on};
    wire  [5:0]  fld = {ramp, schan, cpwr};
    // Short ramp steps keep the analog level slewing checks within a few hundred cycles
    pdc_regs #(.RAMP0_STEP_CYC(20'd4), .RAMP1_STEP_CYC(20'd8), .RAMP2_STEP_CYC(20'd16)) DUT (
        .clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .single_mixer_boost(mix), .reg_rdata_ff(rdata),
        .left_phones_level(lpl), .right_phones_level(rpl), .left_line_level(lll),
        .right_line_level(rll), .single_out_level(sol), .single_out_level_on_ff(lvl_on),
        .left_phones_unsilence_ff(lpu), .right_phones_unsilence_ff(rpu),
        .left_line_unsilence_ff(llu), .right_line_unsilence_ff(rlu),
        .single_out_unsilence_ff(sou), .phones_out_enable_ff(phen), .phones_pin_select_ff(psel),
        .left_line_drive_select_ff(lld), .right_line_drive_select_ff(rld),
        .single_out_drive_select_ff(sod), .pop_guard_low_power_ff(plp), .pop_guard_off_ff(poff),
        .analog_level_ramp_ff(ramp), .right_play_power_ff(rpw), .left_play_power_ff(lpw),
        .converter_single_channel_ff(schan), .converter_invert_ff(inv),
        .emphasis_undo_filter_ff(emph), .converter_power_ff(cpwr),
        .left_converter_atten(latt), .right_converter_atten(ratt),
        .audio_pad_pulls_ff(apad), .ctrl_pad_pulls_ff(cpad));
    // ------------------------------------------------------------
    // Clock, hang guard and access tasks
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Whole run needs well under this many cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            n_mismatch = n_mismatch + 1;
            end_sim;
        end
    end
    task end_sim;
        if (n_mismatch == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks = checks + 1;
        if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    // Strobe stays up for exactly one sampling edge
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk($sformatf("read %h", a), {24'h0, e}, {24'h0, rdata});
    endtask
    // Derived outputs land one edge after the register
    task settle;
        repeat (2) @(negedge clk);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n      = 1'b0;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        reg_addr   = 16'h0;
        reg_wdata  = 8'h0;
        mix        = 2'b01;
        n_mismatch = 0;
        checks     = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        for (k = 0; k < 12; k++) rd(adr[k], rv[k]);
        chk("flags", 17'h1f001, flags);
        chk("levels", 30'h0, {lpl, rpl, lll, rll, sol});
        chk("pads", 16'haaaa, {apad, cpad});
        wr(16'h402e, 8'hff);
        rd(16'h402e, 8'h00);
        for (k = 0; k < 12; k++) wr(adr[k], 8'hff);
        for (k = 0; k < 12; k++) rd(adr[k], mk[k]);
        chk("flags", 17'h1ffff, flags);
        for (k = 0; k < 12; k++) wr(adr[k], 8'h00);
        settle;
        chk("flags", 17'h00001, flags);
        // Drive-on and pin select combine as an OR
        for (k = 0; k < 4; k++) begin
            wr(`PDC_A_HP_L, {6'h0, 1'b1, k[0]});
            wr(`PDC_A_HP_R, {6'h0, 1'b1, k[1]});
            settle;
            chk("phones", {k[1], |k[1:0]}, {psel, phen});
        end
        // Every code of the two-bit fields
        for (k = 0; k < 4; k++) begin
            wr(`PDC_A_CONV, {k[1:0], 4'h0, k[1:0]});
            wr(`PDC_A_POP, {5'h0, k[1:0], 1'b0});
            wr(`PDC_A_PAD_AUD, {4{k[1:0]}});
            wr(`PDC_A_PAD_CTL, {4{k[1:0]}});
            settle;
            chk("fields", {3{k[1:0]}}, fld);
            chk("pads", {8{k[1:0]}}, {apad, cpad});
        end
        wr(`PDC_A_HP_L, {6'h3f, 2'b10});
        wr(`PDC_A_LINE_L, {6'h39, 2'b10});
        wr(`PDC_A_HP_R, {6'h2a, 2'b10});
        wr(`PDC_A_LINE_R, {6'h15, 2'b10});
        settle;
        chk("jump", {6'h3f, 6'h39, 6'h2a, 6'h15}, {lpl, lll, rpl, rll});
        wr(`PDC_A_POP, 8'h00);
        wr(`PDC_A_HP_L, 8'h02);
        settle;
        chk("slow start", 1'b1, lpl >= 6'h3e);
        repeat (300) @(negedge clk);
        chk("ramp end", 6'h00, lpl);
        wr(`PDC_A_POP, 8'h02);
        wr(`PDC_A_HP_L, {6'h10, 2'b10});
        repeat (100) @(negedge clk);
        chk("ramp 42", 1'b1, lpl >= 6'h0a && lpl <= 6'h0e);
        // Common mode overrides the single output level
        wr(`PDC_A_POP, 8'h06);
        @(posedge clk) mix <= 2'b00;
        wr(`PDC_A_MONO, {6'h10, 2'b11});
        repeat (4) @(negedge clk);
        chk("single", {1'b0, 1'b1, 6'h39}, {lvl_on, sod, sol});
        @(posedge clk) mix <= 2'b01;
        repeat (4) @(negedge clk);
        chk("single", {1'b1, 6'h10}, {lvl_on, sol});
        wr(`PDC_A_ATT_L, 8'h03);
        wr(`PDC_A_ATT_R, 8'h02);
        repeat (1000) @(negedge clk);
        chk("atten", {8'h03, 8'h02}, {latt, ratt});
        @(posedge clk) rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        rd(`PDC_A_ATT_L, 8'h00);
        rd(`PDC_A_HP_L, 8'h02);
        end_sim;
    end
endmodule
`default_nettype wire
